// ### hdl/dqcs_regs.vh
`ifndef DQCS_REGS_VH
`define DQCS_REGS_VH

// Register byte offsets
`define DQCS_CTRL_ADDR 8'h00
`define DQCS_TIMER_ADDR 8'h04
`define DQCS_STATUS_ADDR 8'h08
`define DQCS_POINTER_ADDR 8'h0c
`define DQCS_CMD_BASE_SEL 2'h1

// Control register fields
`define DQCS_CTRL_Q1_SW 0
`define DQCS_CTRL_Q2_SW 1
`define DQCS_CTRL_Q1_CONT 2
`define DQCS_CTRL_Q2_CONT 3
`define DQCS_CTRL_RESUME 4
`define DQCS_CTRL_TIMER_EN 5
`define DQCS_CTRL_Q1_IRQ_EN 6
`define DQCS_CTRL_Q2_IRQ_EN 7
`define DQCS_CTRL_RESET 6'h00

// Status flag positions
`define DQCS_ST_CF1 0
`define DQCS_ST_PF1 1
`define DQCS_ST_TOR1 2
`define DQCS_ST_CF2 3
`define DQCS_ST_PF2 4
`define DQCS_ST_TOR2 5

// Command word fields
`define DQCS_CW_PAUSE 6
`define DQCS_CW_END 7
`define DQCS_LAST_INDEX 3'h7

// Queue conditions
`define DQCS_Q_IDLE 3'h0
`define DQCS_Q_ACTIVE 3'h1
`define DQCS_Q_PAUSE 3'h2
`define DQCS_Q_SUSP 3'h3
`define DQCS_Q_PEND 3'h4

// Interrupt source codes, highest priority first
`define DQCS_IRQ_Q1_CF 2'h0
`define DQCS_IRQ_Q1_PF 2'h1
`define DQCS_IRQ_Q2_CF 2'h2
`define DQCS_IRQ_Q2_PF 2'h3

`define DQCS_TIMER_RESET 16'h0000

`endif

// ### hdl/dqcs_sched.v
// Notes on behaviour
// [R1] One conversion at a time, fixed queue priority
// [R2] Triggers: pin, software, loop end, timer
// [R3] Queue 1 trigger aborts and suspends queue 2
// [R4] Resume select clear: queue 2 restarts first word
// [R5] Resume select set: continue at aborted word
// [R6] Trigger on busy queue sets overrun, ignored
// [R7] First extra trigger restarts queue after pass
// [R8] Paused queues use the same overrun handling
// [R9] Queue 2 trigger during queue 1 waits
// [R10] Repeated queue 2 triggers set overrun only; the code also arms one extra queue 2 pass, as for [R7]
// [R11] Trigger while suspended sets overrun
// [R12] End of queue sets completion flag
// [R13] Pause word sets pause flag, waits
// [R14] Each queue condition visible to software
// [R15] Four-bit combined status code, two transitional
// [R16] Freeze lets running conversion finish, then halts
// [R17] After freeze, continue with next word
// [R18] Triggers during freeze are dropped
// [R19] Pending queue 2 trigger survives freeze
// [R20] Suspended queue 2 resumes after freeze
// [R21] Software reads flag, then writes zero
// [R22] Enabled flags request interrupt, fixed priority
// [R23] Simultaneous triggers: queue 1 first
//
// The implementer's own choices: the register addresses and the plain strobed port.
`include "dqcs_regs.vh"

module dqcs_sched (
	input wire clock_in,
	input wire rst_in,
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	input wire high_queue_trigger_in,
	input wire low_queue_trigger_in,
	input wire freeze_in,
	input wire conv_done_in,
	output reg conv_start_out,
	output reg conv_abort_out,
	output reg [5:0] conv_channel_out,
	output reg conv_queue_out,
	output reg [3:0] queue_status_code_out,
	output reg q1_irq_out,
	output reg q2_irq_out,
	output reg [1:0] irq_source_out
);

	// Two-bit condition per queue; the codes with queue 2 pending and queue 1 not active are transitional
	function [3:0] status_code;
		input [2:0] s1;
		input [2:0] s2;
		reg [1:0] a;
		reg [1:0] b;
		begin
			a = (s1 == `DQCS_Q_ACTIVE) ? 2'h2 : (s1 == `DQCS_Q_PAUSE) ? 2'h1 : 2'h0;
			case (s2)
				`DQCS_Q_PAUSE: b = 2'h1;
				`DQCS_Q_ACTIVE: b = 2'h2;
				`DQCS_Q_SUSP: b = 2'h2;
				`DQCS_Q_PEND: b = 2'h3;
				default: b = 2'h0;
			endcase
			status_code = {a, b};
		end
	endfunction

	function is_idle_or_pause;
		input [2:0] s;
		begin
			is_idle_or_pause = (s == `DQCS_Q_IDLE) || (s == `DQCS_Q_PAUSE);
		end
	endfunction

	reg [2:0] t1_sync_r;
	reg [2:0] t2_sync_r;
	reg [1:0] frz_sync_r;
	reg [7:0] cmd_mem [0:15];
	reg [7:2] ctrl_r;
	reg [15:0] period_r;
	reg [15:0] timer_r;
	reg timer_hit_r;
	reg [5:0] flags_r;
	reg [5:0] seen_r;
	reg [2:0] st1_r;
	reg [2:0] st2_r;
	reg [2:0] idx1_r;
	reg [2:0] idx2_r;
	reg extra1_r;
	reg extra2_r;
	reg busy_r;
	reg cur_q_r;

	reg [2:0] st1_nxt;
	reg [2:0] st2_nxt;
	reg [2:0] idx1_nxt;
	reg [2:0] idx2_nxt;
	reg extra1_nxt;
	reg extra2_nxt;
	reg busy_nxt;
	reg cur_q_nxt;
	reg [5:0] set_flags;
	reg abort_nxt;
	reg start_nxt;
	reg [5:0] chan_nxt;
	reg [7:0] word;
	reg last;
	reg t1;
	reg t2;

	wire frozen = frz_sync_r[1];
	wire wr_ctrl = reg_wr_in && (reg_addr_in == `DQCS_CTRL_ADDR);
	wire wr_stat = reg_wr_in && (reg_addr_in == `DQCS_STATUS_ADDR);
	wire rd_stat = reg_rd_in && (reg_addr_in == `DQCS_STATUS_ADDR);
	wire cmd_sel = (reg_addr_in[7:6] == `DQCS_CMD_BASE_SEL);
	wire [5:0] clr_flags = wr_stat ? (seen_r & ~reg_wdata_in[5:0]) : 6'h00;

	always @* begin
		st1_nxt = st1_r;
		st2_nxt = st2_r;
		idx1_nxt = idx1_r;
		idx2_nxt = idx2_r;
		extra1_nxt = extra1_r;
		extra2_nxt = extra2_r;
		busy_nxt = busy_r;
		cur_q_nxt = cur_q_r;
		set_flags = 6'h00;
		abort_nxt = 1'b0;
		start_nxt = 1'b0;
		chan_nxt = conv_channel_out;
		word = 8'h00;
		last = 1'b0;
		// Pin edges, software bit and timer; all dropped while frozen
		t1 = !frozen && ((t1_sync_r[1] && !t1_sync_r[2]) ||
			(wr_ctrl && reg_wdata_in[`DQCS_CTRL_Q1_SW])); // [R2] [R18]
		t2 = !frozen && ((t2_sync_r[1] && !t2_sync_r[2]) || timer_hit_r ||
			(wr_ctrl && reg_wdata_in[`DQCS_CTRL_Q2_SW])); // [R2] [R18]

		// A conversion that finishes is always kept, even under freeze
		if (busy_r && conv_done_in) begin // [R16]
			busy_nxt = 1'b0;
			if (!cur_q_r) begin
				word = cmd_mem[{1'b0, idx1_r}];
				last = word[`DQCS_CW_END] || (idx1_r == `DQCS_LAST_INDEX);
				if (last) begin
					set_flags[`DQCS_ST_CF1] = 1'b1; // [R12]
					idx1_nxt = 3'h0;
					if (ctrl_r[`DQCS_CTRL_Q1_CONT] || extra1_r) // [R2] [R7]
						st1_nxt = `DQCS_Q_ACTIVE;
					else
						st1_nxt = `DQCS_Q_IDLE;
					extra1_nxt = 1'b0;
				end else begin
					idx1_nxt = idx1_r + 3'h1; // [R17]
					if (word[`DQCS_CW_PAUSE]) begin
						set_flags[`DQCS_ST_PF1] = 1'b1; // [R13]
						st1_nxt = extra1_r ? `DQCS_Q_ACTIVE : `DQCS_Q_PAUSE; // [R8]
						extra1_nxt = 1'b0;
					end
				end
			end else begin
				word = cmd_mem[{1'b1, idx2_r}];
				last = word[`DQCS_CW_END] || (idx2_r == `DQCS_LAST_INDEX);
				if (last) begin
					set_flags[`DQCS_ST_CF2] = 1'b1; // [R12]
					idx2_nxt = 3'h0;
					if (ctrl_r[`DQCS_CTRL_Q2_CONT] || extra2_r) // [R2] [R7]
						st2_nxt = `DQCS_Q_ACTIVE;
					else
						st2_nxt = `DQCS_Q_IDLE;
					extra2_nxt = 1'b0;
				end else begin
					idx2_nxt = idx2_r + 3'h1; // [R17]
					if (word[`DQCS_CW_PAUSE]) begin
						set_flags[`DQCS_ST_PF2] = 1'b1; // [R13]
						st2_nxt = extra2_r ? `DQCS_Q_ACTIVE : `DQCS_Q_PAUSE; // [R8]
						extra2_nxt = 1'b0;
					end
				end
			end
		end

		if (t1) begin
			if (st1_nxt == `DQCS_Q_ACTIVE) begin
				set_flags[`DQCS_ST_TOR1] = 1'b1; // [R6]
				extra1_nxt = 1'b1; // [R7]
			end else begin
				st1_nxt = `DQCS_Q_ACTIVE;
				if (st2_nxt == `DQCS_Q_ACTIVE) begin
					st2_nxt = `DQCS_Q_SUSP; // [R3]
					if (!ctrl_r[`DQCS_CTRL_RESUME])
						idx2_nxt = 3'h0; // [R4]
					// Otherwise the pointer stays on the aborted word
					if (busy_nxt && cur_q_r) begin // [R5]
						busy_nxt = 1'b0;
						abort_nxt = 1'b1; // [R3]
					end
				end
			end
		end

		if (t2) begin
			if (is_idle_or_pause(st2_nxt)) begin
				if (st1_nxt == `DQCS_Q_ACTIVE)
					st2_nxt = `DQCS_Q_PEND; // [R9] [R23]
				else
					st2_nxt = `DQCS_Q_ACTIVE;
			end else begin
				set_flags[`DQCS_ST_TOR2] = 1'b1; // [R10] [R11]
				extra2_nxt = 1'b1; // [R7]
			end
		end

		// Pending or suspended queue 2 takes over once queue 1 lets go
		if (st1_nxt != `DQCS_Q_ACTIVE &&
			(st2_nxt == `DQCS_Q_SUSP || st2_nxt == `DQCS_Q_PEND))
			st2_nxt = `DQCS_Q_ACTIVE; // [R9] [R19] [R20]

		// A start waits one cycle after an abort so the core sees them apart
		if (!busy_nxt && !abort_nxt && !frozen) begin // [R1] [R16]
			if (st1_nxt == `DQCS_Q_ACTIVE) begin
				busy_nxt = 1'b1;
				start_nxt = 1'b1;
				cur_q_nxt = 1'b0;
				chan_nxt = cmd_mem[{1'b0, idx1_nxt}][5:0];
			end else if (st2_nxt == `DQCS_Q_ACTIVE) begin
				busy_nxt = 1'b1;
				start_nxt = 1'b1;
				cur_q_nxt = 1'b1;
				chan_nxt = cmd_mem[{1'b1, idx2_nxt}][5:0];
			end
		end
	end

	always @(posedge clock_in) begin
		t1_sync_r <= {t1_sync_r[1:0], high_queue_trigger_in};
		t2_sync_r <= {t2_sync_r[1:0], low_queue_trigger_in};
		frz_sync_r <= {frz_sync_r[0], freeze_in};
		if (reg_wr_in && cmd_sel)
			cmd_mem[reg_addr_in[5:2]] <= reg_wdata_in[7:0];
		if (rst_in) begin
			t1_sync_r <= 3'h0;
			t2_sync_r <= 3'h0;
			frz_sync_r <= 2'h0;
			ctrl_r <= `DQCS_CTRL_RESET;
			period_r <= `DQCS_TIMER_RESET;
			timer_r <= 16'h0000;
			timer_hit_r <= 1'b0;
			flags_r <= 6'h00;
			seen_r <= 6'h00;
			st1_r <= `DQCS_Q_IDLE;
			st2_r <= `DQCS_Q_IDLE;
			idx1_r <= 3'h0;
			idx2_r <= 3'h0;
			extra1_r <= 1'b0;
			extra2_r <= 1'b0;
			busy_r <= 1'b0;
			cur_q_r <= 1'b0;
			conv_start_out <= 1'b0;
			conv_abort_out <= 1'b0;
			conv_channel_out <= 6'h00;
			conv_queue_out <= 1'b0;
			queue_status_code_out <= 4'h0;
			q1_irq_out <= 1'b0;
			q2_irq_out <= 1'b0;
			irq_source_out <= `DQCS_IRQ_Q1_CF;
			reg_rdata_out <= 32'h00000000;
		end else begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata_in[7:2];
			if (reg_wr_in && reg_addr_in == `DQCS_TIMER_ADDR)
				period_r <= reg_wdata_in[15:0];
			// Period zero keeps the timer quiet
			if (ctrl_r[`DQCS_CTRL_TIMER_EN] && period_r != 16'h0000) begin
				timer_hit_r <= (timer_r == period_r - 16'h0001);
				timer_r <= (timer_r == period_r - 16'h0001) ? 16'h0000 :
					timer_r + 16'h0001;
			end else begin
				timer_hit_r <= 1'b0;
				timer_r <= 16'h0000;
			end
			// A new event beats a clear in the same cycle
			flags_r <= (flags_r & ~clr_flags) | set_flags; // [R21]
			if (rd_stat)
				seen_r <= flags_r;
			else if (wr_stat)
				seen_r <= seen_r & reg_wdata_in[5:0];
			st1_r <= st1_nxt;
			st2_r <= st2_nxt;
			idx1_r <= idx1_nxt;
			idx2_r <= idx2_nxt;
			extra1_r <= extra1_nxt;
			extra2_r <= extra2_nxt;
			busy_r <= busy_nxt;
			cur_q_r <= cur_q_nxt;
			conv_start_out <= start_nxt;
			conv_abort_out <= abort_nxt;
			conv_channel_out <= chan_nxt;
			conv_queue_out <= cur_q_nxt;
			queue_status_code_out <= status_code(st1_nxt, st2_nxt); // [R15]
			q1_irq_out <= ctrl_r[`DQCS_CTRL_Q1_IRQ_EN] &&
				(flags_r[`DQCS_ST_CF1] || flags_r[`DQCS_ST_PF1]); // [R22]
			q2_irq_out <= ctrl_r[`DQCS_CTRL_Q2_IRQ_EN] &&
				(flags_r[`DQCS_ST_CF2] || flags_r[`DQCS_ST_PF2]); // [R22]
			if (ctrl_r[`DQCS_CTRL_Q1_IRQ_EN] && flags_r[`DQCS_ST_CF1])
				irq_source_out <= `DQCS_IRQ_Q1_CF; // [R22]
			else if (ctrl_r[`DQCS_CTRL_Q1_IRQ_EN] && flags_r[`DQCS_ST_PF1])
				irq_source_out <= `DQCS_IRQ_Q1_PF;
			else if (ctrl_r[`DQCS_CTRL_Q2_IRQ_EN] && flags_r[`DQCS_ST_CF2])
				irq_source_out <= `DQCS_IRQ_Q2_CF;
			else if (ctrl_r[`DQCS_CTRL_Q2_IRQ_EN] && flags_r[`DQCS_ST_PF2])
				irq_source_out <= `DQCS_IRQ_Q2_PF;
			reg_rdata_out <= 32'h00000000;
			if (reg_rd_in) begin
				if (reg_addr_in == `DQCS_CTRL_ADDR)
					reg_rdata_out <= {24'h000000, ctrl_r, 2'h0};
				else if (reg_addr_in == `DQCS_TIMER_ADDR)
					reg_rdata_out <= {16'h0000, period_r};
				else if (reg_addr_in == `DQCS_STATUS_ADDR)
					reg_rdata_out <= {18'h00000, frozen, busy_r,
						status_code(st1_r, st2_r), 2'h0, flags_r}; // [R14] [R15]
				else if (reg_addr_in == `DQCS_POINTER_ADDR)
					reg_rdata_out <= {17'h00000, st2_r, 1'b0, st1_r, 1'b0,
						idx2_r, 1'b0, idx1_r}; // [R14]
				else if (cmd_sel)
					reg_rdata_out <= {24'h000000, cmd_mem[reg_addr_in[5:2]]};
			end
		end
	end

endmodule

// ### testbench/dqcs_sched_assertions.sv
module dqcs_sched_assertions (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic reg_rd_in,
	input wire logic freeze_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic conv_start_out,
	input wire logic conv_abort_out,
	input wire logic conv_queue_out,
	input wire logic [3:0] queue_status_code_out,
	input wire logic q1_irq_out,
	input wire logic [1:0] irq_source_out
);
	wire [3:0] qs;
	assign qs = queue_status_code_out;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);
	a_single_start: assert property (
		conv_start_out |=> !conv_start_out && !(conv_abort_out && !conv_queue_out))
		else $error("start pulse repeated");
	a_abort_then_q1: assert property (
		conv_abort_out |=> conv_start_out && !conv_queue_out)
		else $error("no queue 1 start after abort");
	a_abort_owner: assert property (conv_abort_out |-> conv_queue_out)
		else $error("abort without queue 2 owner");
	a_brief_code: assert property (
		(qs == 4'h3 || qs == 4'h7) && !freeze_in && !$past(freeze_in) &&
		!$past(freeze_in, 2) |-> ##[1:4] (qs != 4'h3 && qs != 4'h7))
		else $error("transitional code stuck");
	a_irq_order: assert property (q1_irq_out |-> !irq_source_out[1])
		else $error("queue 2 source over queue 1");
	a_freeze_halt: assert property (
		freeze_in [*5] |-> !conv_start_out && !conv_abort_out)
		else $error("activity while frozen");
	a_idle_reset: assert property ($fell(rst_in) |-> qs == 4'h0)
		else $error("queues not idle after reset");
	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data without read");
endmodule

bind dqcs_sched dqcs_sched_assertions chk (.clock_in(clock_in), .rst_in(rst_in),
	.reg_rd_in(reg_rd_in), .freeze_in(freeze_in), .reg_rdata_out(reg_rdata_out),
	.conv_start_out(conv_start_out), .conv_abort_out(conv_abort_out),
	.conv_queue_out(conv_queue_out), .queue_status_code_out(queue_status_code_out),
	.q1_irq_out(q1_irq_out), .irq_source_out(irq_source_out));

// ### testbench/dqcs_conv_model.sv
module dqcs_conv_model (
	input wire logic clock_in,
	input wire logic start_in,
	input wire logic abort_in,
	output logic done_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0;
	initial done_out = 1'b0;
	// Random latency; at least five cycles so a bench write always lands before the done
	always @(posedge clock_in) begin
		done_out <= 1'b0;
		if (abort_in)
			cnt <= 0;
		else if (start_in)
			cnt <= 5 + $urandom % 6;
		else if (cnt > 0) begin
			cnt <= cnt - 1;
			done_out <= cnt == 1;
		end
	end
endmodule

// ### testbench/dqcs_sched_tb.sv
module dqcs_sched_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_in = 0;
	logic rst_in = 1;
	logic wr = 0;
	logic rd = 0;
	logic t1 = 0;
	logic t2 = 0;
	logic frz = 0;
	logic [7:0] addr = 0;
	logic [31:0] wdata = 0;
	logic [31:0] rdata, v;
	logic done, start, abort, cq;
	logic [5:0] chn;
	logic [3:0] qs;
	logic q1_irq, q2_irq;
	logic [1:0] irq_src;
	int wt;
	logic [5:0] ch [16];
	int errors = 0;
	int n_tests = 0;
	initial forever #12.5 clock_in = ~clock_in;
	dqcs_sched dut (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.high_queue_trigger_in(t1), .low_queue_trigger_in(t2), .freeze_in(frz),
		.conv_done_in(done), .conv_start_out(start), .conv_abort_out(abort),
		.conv_channel_out(chn), .conv_queue_out(cq), .queue_status_code_out(qs),
		.q1_irq_out(q1_irq), .q2_irq_out(q2_irq), .irq_source_out(irq_src));
	dqcs_conv_model conv (.clock_in(clock_in), .start_in(start), .abort_in(abort),
		.done_out(done));
	task automatic complete_run;
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clock_in);
		wr <= 0;
	endtask
	// Outputs are read at the edge, so they hold the settled value of the cycle before
	task automatic rdr(input logic [7:0] a);
		@(posedge clock_in);
		addr <= a;
		rd <= 1;
		@(posedge clock_in);
		rd <= 0;
		@(posedge clock_in);
		v = rdata;
	endtask
	task automatic run(input logic q, input int b, input int n);
		int k;
		for (int i = b; i < b + n; i++) begin
			k = 0;
			do begin
				@(posedge clock_in);
				k++;
			end while (start !== 1'b1 && k < 400);
			chk(k < 400, 1);
			if (k >= 400)
				complete_run();
			chk({cq, chn}, {q, ch[i]});
		end
	endtask
	task automatic fl(input logic [5:0] e);
		int k = 0;
		while (qs !== 4'h0 && k < 400) begin
			@(posedge clock_in);
			k++;
		end
		chk(k < 400, 1);
		if (k >= 400)
			complete_run();
		rdr(8'h0c);
		chk(v[15:8], 0);
		rdr(8'h08);
		chk(v[5:0], e);
		wrr(8'h08, 0);
		rdr(8'h08);
		chk(v[5:0], 0);
	endtask
	task automatic pls(input logic q);
		@(posedge clock_in);
		{t2, t1} <= q ? 2'b10 : 2'b01;
		repeat (3) @(posedge clock_in);
		{t2, t1} <= 2'b00;
		repeat (3) @(posedge clock_in);
	endtask
	// Two extra pin triggers on queue q while queue 1 is mid-pass
	task automatic busy(input logic q);
		wrr(0, 1);
		run(0, 0, 1);
		fork
			begin
				pls(q);
				pls(q);
			end
			run(0, 1, 3);
		join
	endtask
	initial begin
		void'($urandom(32'h6b7f1aa1));
		repeat (4) @(posedge clock_in);
		rst_in <= 0;
		for (int i = 0; i < 16; i++) begin
			ch[i] = 6'($urandom);
			wrr(8'h40 + 8'(4 * i), {24'h0, i % 8 == 3, 1'b0, ch[i]});
		end
		rdr(8'h30);
		chk(v, 0);
		wrr(0, 1);
		run(0, 0, 4);
		fl(6'h01);
		for (int r = 0; r < 2; r++) begin
			wrr(0, 2 | r << 4);
			run(1, 8, 2);
			repeat ($urandom % 2) @(posedge clock_in);
			wrr(0, 1 | r << 4);
			@(posedge clock_in);
			chk(abort, 1);
			run(0, 0, 1);
			chk(qs, 4'ha);
			run(0, 1, 3);
			run(1, 8 + r, 4 - r);
			fl(6'h09);
		end
		busy(0);
		run(0, 0, 4);
		fl(6'h05);
		busy(1);
		run(1, 8, 4);
		run(1, 8, 4);
		fl(6'h29);
		wrr(0, 1);
		run(0, 0, 1);
		@(posedge clock_in) frz <= 1;
		repeat (30) @(posedge clock_in);
		wrr(0, 3);
		@(posedge clock_in) frz <= 0;
		run(0, 1, 3);
		fl(6'h01);
		wrr(0, 3);
		run(0, 0, 4);
		run(1, 8, 4);
		fl(6'h09);
		wrr(8'h44, {24'h0, 2'b01, ch[1]});
		wrr(0, 32'h41);
		run(0, 0, 2);
		wt = 0;
		while (qs !== 4'h4 && wt < 400) begin
			@(posedge clock_in);
			wt++;
		end
		chk(wt < 400, 1);
		if (wt >= 400)
			complete_run();
		repeat (2) @(posedge clock_in);
		chk({q2_irq, q1_irq, irq_src}, 4'h5);
		wrr(0, 32'h41);
		run(0, 2, 2);
		fl(6'h03);
		chk(q1_irq, 0);
		complete_run();
	end
endmodule
